// ===== design/pdm_ctrl.sv
`timescale 1ns/1ns
// What this block does
// - clear standby: sleep or subsleep entered
// - standby set: standby/watch, or watch from subactive
// - settle code picks one of eight waits
// - settle wait before active after standby/watch
// - code 101 is the two-state external clock wait
// - low-speed flag picks clock after watch
// - register one bit 2 reads one
// - medium divider sixteen to one-twenty-eight
// - register two bits 7..5 read one
// - noise sampling at osc/16 or osc/4
// - no direct transfer: ordinary low-power targets
// - direct from high speed: medium or subactive
// - direct from medium speed: high or subactive
// - direct from subactive: high or medium speed
// - medium flag picks active mode after wake
// - subactive clock watch/8, /4 or /2
// - subactive divider frozen while in subactive
// - reset values 07 and F0
// - held external interrupts ignored in standby/watch
// - standby keeps port data, outputs high-impedance
// - standby entered with timer-watch clear
// - watch entered with standby and timer-watch set
module pdm_ctrl #(
  parameter int SETTLE_0 = pdm_pkg::SETTLE_STATES_0,
  parameter int SETTLE_1 = pdm_pkg::SETTLE_STATES_1,
  parameter int SETTLE_2 = pdm_pkg::SETTLE_STATES_2,
  parameter int SETTLE_3 = pdm_pkg::SETTLE_STATES_3,
  parameter int SETTLE_4 = pdm_pkg::SETTLE_STATES_4
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic sleep_req_i,
  input wire logic wake_irq_i,
  input wire logic watch_tick_i,
  output logic [2:0] mode_o,
  output logic cpu_run_o,
  output logic sys_osc_on_o,
  output logic port_hiz_o,
  output logic ext_irq_hold_o,
  output logic settle_busy_o,
  output logic mid_clk_en_o,
  output logic sub_clk_en_o,
  output logic noise_smp_en_o
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [7:0] ctrl_one_reg;
  logic [7:0] ctrl_two_reg;
  logic timer_watch_reg;
  pdm_pkg::pdm_mode_t mode_reg;
  pdm_pkg::pdm_mode_t mode_next;
  pdm_pkg::pdm_mode_t sleep_target;
  logic [31:0] rdata_next;
  logic addr_hit;
  logic wr_fire;
  logic settle_start;
  logic settle_busy;
  logic settle_done;
  logic [7:0] mid_cnt_reg;
  logic [3:0] noise_cnt_reg;
  logic [3:0] sub_cnt_reg;
  logic [7:0] mid_limit;
  logic [3:0] sub_limit;
  logic [3:0] noise_limit;
  logic software_standby_sel;
  logic [2:0] settle_wait_code;
  logic low_speed_flag;
  logic mid_div_hi;
  logic mid_div_lo;
  logic noise_sample_sel;
  logic direct_transfer_flag;
  logic medium_speed_flag;
  logic sub_div_hi;
  logic sub_div_lo;
  logic timer_watch_bit;
  logic is_active;

  // field views of the control registers
  assign software_standby_sel = ctrl_one_reg[pdm_pkg::SOFT_STBY_BIT];
  assign settle_wait_code = ctrl_one_reg[pdm_pkg::SETTLE_HI_BIT:pdm_pkg::SETTLE_LO_BIT];
  assign low_speed_flag = ctrl_one_reg[pdm_pkg::LOW_SPEED_BIT];
  assign mid_div_hi = ctrl_one_reg[pdm_pkg::MID_DIV_HI_BIT];
  assign mid_div_lo = ctrl_one_reg[pdm_pkg::MID_DIV_LO_BIT];
  assign noise_sample_sel = ctrl_two_reg[pdm_pkg::NOISE_SEL_BIT];
  assign direct_transfer_flag = ctrl_two_reg[pdm_pkg::DIRECT_BIT];
  assign medium_speed_flag = ctrl_two_reg[pdm_pkg::MEDIUM_BIT];
  assign sub_div_hi = ctrl_two_reg[pdm_pkg::SUB_DIV_HI_BIT];
  assign sub_div_lo = ctrl_two_reg[pdm_pkg::SUB_DIV_LO_BIT];
  assign timer_watch_bit = timer_watch_reg;
  assign is_active = (mode_reg == pdm_pkg::PDM_ACT_HI) || (mode_reg == pdm_pkg::PDM_ACT_MID);

  ////////////////////////////////////////////////////////////////////////////
  // apb slave, one wait state on every access

  // address decode
  always_comb begin
    addr_hit = 1'b1;
    case (paddr_i)
      pdm_pkg::ADDR_CTRL_ONE: rdata_next = {24'h000000, ctrl_one_reg};
      pdm_pkg::ADDR_CTRL_TWO: rdata_next = {24'h000000, ctrl_two_reg};
      pdm_pkg::ADDR_TIMER_WATCH: rdata_next = {31'h00000000, timer_watch_reg};
      pdm_pkg::ADDR_STATUS: rdata_next = {28'h0000000, settle_busy, mode_reg};
      default: begin
        rdata_next = 32'h00000000;
        addr_hit = 1'b0;
      end
    endcase
  end

  assign wr_fire = psel_i && penable_i && pready_o && pwrite_i && addr_hit && pstrb_i[0];

  // ready, read data and error answer
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      pready_o <= 1'b0;
      prdata_o <= 32'h00000000;
      pslverr_o <= 1'b0;
    end else if (psel_i && penable_i && !pready_o) begin
      pready_o <= 1'b1;
      prdata_o <= pwrite_i ? 32'h00000000 : rdata_next;
      pslverr_o <= !addr_hit;
    end else begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end

  // control register one, bit 2 fixed at one
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      ctrl_one_reg <= pdm_pkg::RST_CTRL_ONE;
    end else if (wr_fire && paddr_i == pdm_pkg::ADDR_CTRL_ONE) begin
      ctrl_one_reg <= (pwdata_i[7:0] & pdm_pkg::WR_MASK_ONE) | pdm_pkg::FIXED_ONE;
    end
  end

  // control register two, bits 7..5 fixed, divider locked in subactive
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      ctrl_two_reg <= pdm_pkg::RST_CTRL_TWO;
    end else if (wr_fire && paddr_i == pdm_pkg::ADDR_CTRL_TWO) begin
      if (mode_reg == pdm_pkg::PDM_SUBACT) begin
        ctrl_two_reg <= (pwdata_i[7:0] & pdm_pkg::WR_MASK_TWO & ~pdm_pkg::SUB_DIV_MASK)
          | (ctrl_two_reg & pdm_pkg::SUB_DIV_MASK) | pdm_pkg::FIXED_TWO;
      end else begin
        ctrl_two_reg <= (pwdata_i[7:0] & pdm_pkg::WR_MASK_TWO) | pdm_pkg::FIXED_TWO;
      end
    end
  end

  // timer-watch selection copy
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      timer_watch_reg <= 1'b0;
    end else if (wr_fire && paddr_i == pdm_pkg::ADDR_TIMER_WATCH) begin
      timer_watch_reg <= pwdata_i[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode selection on a sleep instruction

  // target from current mode and bits of this cycle
  always_comb begin
    sleep_target = mode_reg;
    if (is_active) begin
      if (direct_transfer_flag && software_standby_sel && timer_watch_bit && low_speed_flag) begin
        sleep_target = pdm_pkg::PDM_SUBACT;
      end else if (direct_transfer_flag && !software_standby_sel && !low_speed_flag
          && mode_reg == pdm_pkg::PDM_ACT_HI && medium_speed_flag) begin
        sleep_target = pdm_pkg::PDM_ACT_MID;
      end else if (direct_transfer_flag && !software_standby_sel && !low_speed_flag
          && mode_reg == pdm_pkg::PDM_ACT_MID && !medium_speed_flag) begin
        sleep_target = pdm_pkg::PDM_ACT_HI;
      end else if (software_standby_sel && timer_watch_bit) begin
        sleep_target = pdm_pkg::PDM_WATCH;
      end else if (software_standby_sel) begin
        sleep_target = pdm_pkg::PDM_STANDBY;
      end else begin
        sleep_target = medium_speed_flag ? pdm_pkg::PDM_SLEEP_MID : pdm_pkg::PDM_SLEEP_HI;
      end
    end else if (mode_reg == pdm_pkg::PDM_SUBACT) begin
      if (direct_transfer_flag && software_standby_sel && timer_watch_bit && !low_speed_flag) begin
        sleep_target = medium_speed_flag ? pdm_pkg::PDM_ACT_MID : pdm_pkg::PDM_ACT_HI;
      end else if (software_standby_sel) begin
        sleep_target = pdm_pkg::PDM_WATCH;
      end else begin
        sleep_target = pdm_pkg::PDM_SUBSLEEP;
      end
    end
  end

  // wake from standby or watch to active waits for the oscillator
  assign settle_start = wake_irq_i && !settle_busy
    && (mode_reg == pdm_pkg::PDM_STANDBY || (mode_reg == pdm_pkg::PDM_WATCH && !low_speed_flag));

  pdm_settle #(
    .SETTLE_0(SETTLE_0),
    .SETTLE_1(SETTLE_1),
    .SETTLE_2(SETTLE_2),
    .SETTLE_3(SETTLE_3),
    .SETTLE_4(SETTLE_4)
  ) u_settle (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .start_i(settle_start),
    .code_i(settle_wait_code),
    .busy_o(settle_busy),
    .done_o(settle_done)
  );

  // next mode
  always_comb begin
    mode_next = mode_reg;
    case (mode_reg)
      pdm_pkg::PDM_ACT_HI, pdm_pkg::PDM_ACT_MID, pdm_pkg::PDM_SUBACT: begin
        if (sleep_req_i) begin
          mode_next = sleep_target;
        end
      end
      pdm_pkg::PDM_SLEEP_HI: begin
        if (wake_irq_i) begin
          mode_next = pdm_pkg::PDM_ACT_HI;
        end
      end
      pdm_pkg::PDM_SLEEP_MID: begin
        if (wake_irq_i) begin
          mode_next = pdm_pkg::PDM_ACT_MID;
        end
      end
      pdm_pkg::PDM_SUBSLEEP: begin
        if (wake_irq_i) begin
          mode_next = pdm_pkg::PDM_SUBACT;
        end
      end
      pdm_pkg::PDM_STANDBY, pdm_pkg::PDM_WATCH: begin
        if (settle_done) begin
          mode_next = medium_speed_flag ? pdm_pkg::PDM_ACT_MID : pdm_pkg::PDM_ACT_HI;
        end else if (mode_reg == pdm_pkg::PDM_WATCH && wake_irq_i && low_speed_flag && !settle_busy) begin
          mode_next = pdm_pkg::PDM_SUBACT;
        end
      end
      default: mode_next = pdm_pkg::PDM_ACT_HI;
    endcase
  end

  // mode register
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      mode_reg <= pdm_pkg::PDM_ACT_HI;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // per-mode status outputs, aligned with the mode register
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      mode_o <= 3'h0;
      cpu_run_o <= 1'b1;
      sys_osc_on_o <= 1'b1;
      port_hiz_o <= 1'b0;
      ext_irq_hold_o <= 1'b0;
      settle_busy_o <= 1'b0;
    end else begin
      mode_o <= mode_next;
      cpu_run_o <= (mode_next == pdm_pkg::PDM_ACT_HI) || (mode_next == pdm_pkg::PDM_ACT_MID)
        || (mode_next == pdm_pkg::PDM_SUBACT);
      sys_osc_on_o <= (mode_next inside {pdm_pkg::PDM_ACT_HI, pdm_pkg::PDM_ACT_MID,
        pdm_pkg::PDM_SLEEP_HI, pdm_pkg::PDM_SLEEP_MID}) || settle_start || (settle_busy && !settle_done);
      port_hiz_o <= (mode_next == pdm_pkg::PDM_STANDBY);
      ext_irq_hold_o <= (mode_next == pdm_pkg::PDM_STANDBY) || (mode_next == pdm_pkg::PDM_WATCH);
      settle_busy_o <= settle_start || (settle_busy && !settle_done);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock enable dividers

  assign mid_limit = 8'((pdm_pkg::MID_DIV_BASE << {mid_div_hi, mid_div_lo}) - 8'h01);
  assign noise_limit = noise_sample_sel ? pdm_pkg::NOISE_FAST : pdm_pkg::NOISE_SLOW;
  assign sub_limit = sub_div_hi ? 4'h1 : (sub_div_lo ? 4'h3 : 4'((pdm_pkg::SUB_DIV_BASE) - 4'h1));

  // medium-speed enable, only in medium modes
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      mid_cnt_reg <= 8'h00;
      mid_clk_en_o <= 1'b0;
    end else if (mid_cnt_reg >= mid_limit) begin
      mid_cnt_reg <= 8'h00;
      mid_clk_en_o <= (mode_reg == pdm_pkg::PDM_ACT_MID) || (mode_reg == pdm_pkg::PDM_SLEEP_MID);
    end else begin
      mid_cnt_reg <= mid_cnt_reg + 8'h01;
      mid_clk_en_o <= 1'b0;
    end
  end

  // system clock noise sampling enable while the oscillator runs
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      noise_cnt_reg <= 4'h0;
      noise_smp_en_o <= 1'b0;
    end else if (noise_cnt_reg >= noise_limit) begin
      noise_cnt_reg <= 4'h0;
      noise_smp_en_o <= sys_osc_on_o;
    end else begin
      noise_cnt_reg <= noise_cnt_reg + 4'h1;
      noise_smp_en_o <= 1'b0;
    end
  end

  // subactive cpu enable from watch clock ticks
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      sub_cnt_reg <= 4'h0;
      sub_clk_en_o <= 1'b0;
    end else if (watch_tick_i && sub_cnt_reg >= sub_limit) begin
      sub_cnt_reg <= 4'h0;
      sub_clk_en_o <= (mode_reg == pdm_pkg::PDM_SUBACT);
    end else begin
      if (watch_tick_i) begin
        sub_cnt_reg <= sub_cnt_reg + 4'h1;
      end
      sub_clk_en_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  sequence s_sleep_act;
    sleep_req_i && is_active;
  endsequence

  sequence s_sleep_sub;
    sleep_req_i && mode_reg == pdm_pkg::PDM_SUBACT;
  endsequence

  sleep_sel_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_sleep_act ##0 (!software_standby_sel && !direct_transfer_flag)
    |=> mode_reg inside {pdm_pkg::PDM_SLEEP_HI, pdm_pkg::PDM_SLEEP_MID})
    else $error("sleep mode not entered");

  subsleep_sel_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_sleep_sub ##0 !software_standby_sel |=> mode_reg == pdm_pkg::PDM_SUBSLEEP)
    else $error("subsleep mode not entered");

  standby_sel_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_sleep_act ##0 (software_standby_sel && !low_speed_flag && !timer_watch_bit)
    |=> mode_reg == pdm_pkg::PDM_STANDBY ##1 port_hiz_o && ext_irq_hold_o)
    else $error("standby entry wrong");

  watch_sel_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (s_sleep_act or s_sleep_sub) ##0 (software_standby_sel && timer_watch_bit && !direct_transfer_flag)
    |=> mode_reg == pdm_pkg::PDM_WATCH)
    else $error("watch mode not entered");

  direct_mid_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    sleep_req_i && mode_reg == pdm_pkg::PDM_ACT_HI && direct_transfer_flag && !software_standby_sel
    && medium_speed_flag && !low_speed_flag |=> mode_reg == pdm_pkg::PDM_ACT_MID)
    else $error("direct move to medium speed missed");

  direct_sub_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_sleep_sub ##0 (direct_transfer_flag && software_standby_sel && timer_watch_bit && !low_speed_flag)
    |=> mode_reg == ($past(medium_speed_flag) ? pdm_pkg::PDM_ACT_MID : pdm_pkg::PDM_ACT_HI))
    else $error("direct move from subactive wrong");

  sub_lock_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    mode_reg == pdm_pkg::PDM_SUBACT |=> ctrl_two_reg[1:0] == $past(ctrl_two_reg[1:0]))
    else $error("subactive divider changed in subactive");

  settle_hold_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    settle_start ##1 (settle_busy && !settle_done) |=> !cpu_run_o && mode_reg == $past(mode_reg))
    else $error("active mode before settling ended");

  fixed_one_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    psel_i && penable_i && !pwrite_i && !pready_o && paddr_i == pdm_pkg::ADDR_CTRL_ONE
    |=> pready_o && prdata_o[2])
    else $error("register one bit 2 not one");

  fixed_two_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
    psel_i && penable_i && !pwrite_i && !pready_o && paddr_i == pdm_pkg::ADDR_CTRL_TWO
    |=> pready_o && prdata_o[7:5] == 3'h7)
    else $error("register two bits 7..5 not one");

endmodule

// ===== design/pdm_pkg.sv
package pdm_pkg;

  // register indices as printed, byte address is four times the index
  localparam logic [15:0] IDX_CTRL_ONE = 16'hFFF0;
  localparam logic [15:0] IDX_CTRL_TWO = 16'hFFF1;
  localparam logic [15:0] IDX_TIMER_WATCH = 16'hFFF2;
  localparam logic [15:0] IDX_STATUS = 16'hFFF3;
  localparam logic [31:0] ADDR_CTRL_ONE = {14'h0000, IDX_CTRL_ONE, 2'h0};
  localparam logic [31:0] ADDR_CTRL_TWO = {14'h0000, IDX_CTRL_TWO, 2'h0};
  localparam logic [31:0] ADDR_TIMER_WATCH = {14'h0000, IDX_TIMER_WATCH, 2'h0};
  localparam logic [31:0] ADDR_STATUS = {14'h0000, IDX_STATUS, 2'h0};

  // reset values and bit handling
  localparam logic [7:0] RST_CTRL_ONE = 8'h07;
  localparam logic [7:0] RST_CTRL_TWO = 8'hF0;
  localparam logic [7:0] WR_MASK_ONE = 8'hFB;
  localparam logic [7:0] FIXED_ONE = 8'h04;
  localparam logic [7:0] WR_MASK_TWO = 8'h1F;
  localparam logic [7:0] FIXED_TWO = 8'hE0;
  localparam logic [7:0] SUB_DIV_MASK = 8'h03;

  // field positions in control register one
  localparam int SOFT_STBY_BIT = 7;
  localparam int SETTLE_HI_BIT = 6;
  localparam int SETTLE_LO_BIT = 4;
  localparam int LOW_SPEED_BIT = 3;
  localparam int MID_DIV_HI_BIT = 1;
  localparam int MID_DIV_LO_BIT = 0;
  // field positions in control register two
  localparam int NOISE_SEL_BIT = 4;
  localparam int DIRECT_BIT = 3;
  localparam int MEDIUM_BIT = 2;
  localparam int SUB_DIV_HI_BIT = 1;
  localparam int SUB_DIV_LO_BIT = 0;
  // status register layout
  localparam int STAT_BUSY_BIT = 3;

  // settling wait in states, one state is one clock cycle
  localparam int SETTLE_STATES_0 = 8192;
  localparam int SETTLE_STATES_1 = 16384;
  localparam int SETTLE_STATES_2 = 32768;
  localparam int SETTLE_STATES_3 = 65536;
  localparam int SETTLE_STATES_4 = 131072;
  localparam int SETTLE_STATES_5 = 2;
  localparam int SETTLE_STATES_6 = 8;
  localparam int SETTLE_STATES_7 = 16;

  // divider periods
  localparam logic [7:0] MID_DIV_BASE = 8'h10;
  localparam logic [3:0] NOISE_SLOW = 4'hF;
  localparam logic [3:0] NOISE_FAST = 4'h3;
  localparam logic [3:0] SUB_DIV_BASE = 4'h8;

  // operating modes, plain binary in declaration order
  typedef enum logic [2:0] {
    PDM_ACT_HI = 3'h0,
    PDM_ACT_MID = 3'h1,
    PDM_SLEEP_HI = 3'h2,
    PDM_SLEEP_MID = 3'h3,
    PDM_SUBSLEEP = 3'h4,
    PDM_SUBACT = 3'h5,
    PDM_STANDBY = 3'h6,
    PDM_WATCH = 3'h7
  } pdm_mode_t;

endpackage

// ===== design/pdm_settle.sv
`timescale 1ns/1ns
// oscillator settling counter, one clock per state
module pdm_settle #(
  parameter int SETTLE_0 = pdm_pkg::SETTLE_STATES_0,
  parameter int SETTLE_1 = pdm_pkg::SETTLE_STATES_1,
  parameter int SETTLE_2 = pdm_pkg::SETTLE_STATES_2,
  parameter int SETTLE_3 = pdm_pkg::SETTLE_STATES_3,
  parameter int SETTLE_4 = pdm_pkg::SETTLE_STATES_4
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic start_i,
  input wire logic [2:0] code_i,
  output logic busy_o,
  output logic done_o
);

  logic [17:0] cnt_reg;
  logic [17:0] len_next;
  logic busy_reg;

  // wait length per code
  always_comb begin
    case (code_i)
      3'h0: len_next = 18'(SETTLE_0 - 1);
      3'h1: len_next = 18'(SETTLE_1 - 1);
      3'h2: len_next = 18'(SETTLE_2 - 1);
      3'h3: len_next = 18'(SETTLE_3 - 1);
      3'h4: len_next = 18'(SETTLE_4 - 1);
      3'h5: len_next = 18'(pdm_pkg::SETTLE_STATES_5 - 1);
      3'h6: len_next = 18'(pdm_pkg::SETTLE_STATES_6 - 1);
      default: len_next = 18'(pdm_pkg::SETTLE_STATES_7 - 1);
    endcase
  end

  // count down, done in the last state of the wait
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      cnt_reg <= 18'h00000;
      busy_reg <= 1'b0;
    end else if (start_i && !busy_reg) begin
      cnt_reg <= len_next;
      busy_reg <= 1'b1;
    end else if (busy_reg) begin
      if (cnt_reg == 18'h00000) begin
        busy_reg <= 1'b0;
      end else begin
        cnt_reg <= cnt_reg - 18'h00001;
      end
    end
  end

  assign busy_o = busy_reg;
  assign done_o = busy_reg && (cnt_reg == 18'h00000);

endmodule

// ===== testbench/pdm_cpu.sv
`timescale 1ns/1ns
// cpu side: apb master plus sleep and wake strobes
module pdm_cpu (
  input wire logic clk_i,
  input wire logic pready_i,
  input wire logic pslverr_i,
  input wire logic [31:0] prdata_i,
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [31:0] paddr_o,
  output logic [31:0] pwdata_o,
  output logic [3:0] pstrb_o,
  output logic sleep_req_o,
  output logic wake_irq_o
);
  // idle bus at time zero
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = 32'h00000000;
    pwdata_o = 32'h00000000;
    pstrb_o = 4'hF;
    sleep_req_o = 1'b0;
    wake_irq_o = 1'b0;
  end
  //////////////////////////////////////////////////////////////////
  // one transfer, request held until pready is seen high
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e, output logic ok);
    int n;
    @(posedge clk_i);
    psel_o <= 1'b1;
    pwrite_o <= w;
    paddr_o <= a;
    pwdata_o <= d;
    @(posedge clk_i);
    penable_o <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_i !== 1'b1 && n < 50);
    q = prdata_i;
    e = pslverr_i;
    ok = (pready_i === 1'b1);
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    paddr_o <= ~a; // released lines show junk
    pwdata_o <= ~d;
  endtask
  // one-cycle sleep instruction strobe
  task automatic slp();
    @(posedge clk_i);
    sleep_req_o <= 1'b1;
    @(posedge clk_i);
    sleep_req_o <= 1'b0;
  endtask
  // one-cycle accepted wake interrupt
  task automatic wak();
    @(posedge clk_i);
    wake_irq_o <= 1'b1;
    @(posedge clk_i);
    wake_irq_o <= 1'b0;
  endtask
endmodule

// ===== testbench/tb.sv
`timescale 1ns/1ns
module tb;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic tick = 1'b0;
  logic psel, penable, pwrite, slp, wak, pready, pslverr;
  logic run, osc, hiz, hold, busy, mid, sub, nse;
  logic [31:0] paddr, pwdata, prdata;
  logic [3:0] pstrb;
  logic [2:0] mode;
  int fails = 0;
  int checks = 0;
  int tc = 0;
  int nt[8] = '{20, 24, 28, 32, 36, 2, 8, 16};
  localparam logic [31:0] A1 = pdm_pkg::ADDR_CTRL_ONE;
  localparam logic [31:0] A2 = pdm_pkg::ADDR_CTRL_TWO;
  localparam logic [31:0] AT = pdm_pkg::ADDR_TIMER_WATCH;
  always #2 clk_i = ~clk_i;
  // watch clock tick every fourth cycle
  always @(posedge clk_i) begin
    tc <= tc + 1;
    tick <= (tc % 4 == 3);
  end
  pdm_ctrl #(.SETTLE_0(20), .SETTLE_1(24), .SETTLE_2(28), .SETTLE_3(32), .SETTLE_4(36)) dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .sleep_req_i(slp), .wake_irq_i(wak), .watch_tick_i(tick), .mode_o(mode),
    .cpu_run_o(run), .sys_osc_on_o(osc), .port_hiz_o(hiz), .ext_irq_hold_o(hold),
    .settle_busy_o(busy), .mid_clk_en_o(mid), .sub_clk_en_o(sub), .noise_smp_en_o(nse));
  pdm_cpu cpu (
    .clk_i(clk_i), .pready_i(pready), .pslverr_i(pslverr), .prdata_i(prdata), .psel_o(psel),
    .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata), .pstrb_o(pstrb),
    .sleep_req_o(slp), .wake_irq_o(wak));
  //////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // a wait that ran out is a mismatch, then the run ends
  task automatic give_up();
    fails++;
    tally_and_finish();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic e, ok;
    cpu.xfer(1'b1, a, {24'h000000, d}, q, e, ok);
    if (!ok) give_up();
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] q;
    logic e, ok;
    cpu.xfer(1'b0, a, 32'h00000000, q, e, ok);
    if (!ok) give_up();
    chk(q, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask
  // mode plus derived pin states, expected from the mode alone
  function automatic logic [31:0] ex(input logic [2:0] m);
    return {25'h0, m, m == 3'h0 || m == 3'h1 || m == 3'h5, m == 3'h6, m == 3'h6 || m == 3'h7, m < 3'h4};
  endfunction
  // program, sleep, check; then wake (wm 8 = none) and count settle cycles
  task automatic go(input logic [7:0] r1, r2, input logic tw, input logic [2:0] sm,
                    input logic [3:0] wm, input int nb);
    int n, b;
    wr(A1, r1);
    wr(A2, r2);
    wr(AT, {7'h00, tw});
    cpu.slp();
    @(posedge clk_i);
    #1 chk({25'h0, mode, run, hiz, hold, osc}, ex(sm));
    if (wm == 4'h8) return;
    cpu.wak();
    n = 0;
    // first settling cycle stands right after the wake edge
    #1 b = busy;
    if (nb > 0) chk({31'h0, osc}, 32'h1);
    do begin
      @(posedge clk_i);
      #1 b += busy;
      n++;
    end while (mode !== wm[2:0] && n < 300);
    if (n >= 300) give_up();
    chk(b, nb);
    chk({25'h0, mode, run, hiz, hold, osc}, ex(wm[2:0]));
  endtask
  // interval between two pulses of mid(0), sub(1) or noise(2) enable
  task automatic per(input int s, input int x);
    int n;
    logic p;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(posedge clk_i);
        #1 n++;
        p = (s == 0) ? mid : (s == 1) ? sub : nse;
      end while (p !== 1'b1 && n < 600);
    end
    if (n >= 600) give_up();
    chk(n, x);
  endtask
  //////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd(A1, 32'h07, 1'b0);
    rd(A2, 32'hF0, 1'b0);
    per(2, 4);
    wr(A1, 8'h00);
    rd(A1, 32'h04, 1'b0);
    wr(A2, 8'h00);
    rd(A2, 32'hE0, 1'b0);
    per(2, 16);
    rd(32'h00000100, 32'h0, 1'b1);
    $display("test registers done");
    go(8'h00, 8'hE0, 1'b0, 3'h2, 4'h0, 0);
    go(8'h00, 8'hE4, 1'b0, 3'h3, 4'h1, 0);
    per(0, 16);
    go(8'h00, 8'hE8, 1'b0, 3'h0, 4'h8, 0);
    go(8'h00, 8'hEC, 1'b0, 3'h1, 4'h8, 0);
    go(8'h88, 8'hE8, 1'b1, 3'h5, 4'h8, 0);
    per(1, 32);
    wr(A2, 8'hE3);
    rd(A2, 32'hE0, 1'b0);
    go(8'h00, 8'hE0, 1'b0, 3'h4, 4'h5, 0);
    go(8'h88, 8'hE0, 1'b1, 3'h7, 4'h5, 0);
    go(8'h80, 8'hEC, 1'b1, 3'h1, 4'h8, 0);
    go(8'h80, 8'hE0, 1'b1, 3'h7, 4'h0, 20);
    $display("test transitions done");
    // code 5 stands for an external clock feed here
    for (int c = 0; c < 8; c++) begin
      go({1'b1, 3'(c), 4'h0}, 8'hE0, 1'b0, 3'h6, 4'h0, nt[c]);
    end
    $display("test settling done");
    @(posedge clk_i);
    nrst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd(A1, 32'h07, 1'b0);
    rd(A2, 32'hF0, 1'b0);
    rd(pdm_pkg::ADDR_STATUS, 32'h0, 1'b0);
    $display("test reset done");
    tally_and_finish();
  end
endmodule
